// [rtl/tmc_channel_mode.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_channel_mode import tmc_pkg::*; #(
	parameter int unsigned CHANNEL = 0
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic mode_wr_en,
	input wire logic [15:0] mode_wr_data,
	output logic [15:0] mode_rd_data,
	input wire logic timer_input_pin,
	input wire logic master_irq,
	input wire logic sw_start,
	output logic start_trigger,
	output logic capture_trigger,
	output logic is_master,
	output logic half_width,
	output logic [1:0] op_clock_select,
	output logic count_clock_pin,
	output logic count_up,
	output logic start_irq_enable,
	output var tmc_op_t op_mode,
	output logic config_error
);
	// =====================================================
	// channel capabilities
	localparam bit HAS_ROLE = (CHANNEL == TMC_CH_MASTER);
	localparam bit HAS_SPLIT = (CHANNEL == TMC_CH_SPLIT_A) || (CHANNEL == TMC_CH_SPLIT_B);
	localparam logic [15:0] WMASK = (HAS_ROLE || HAS_SPLIT) ?
		(TMC_WMASK_BASE | TMC_BIT11_MASK) : TMC_WMASK_BASE;

	logic [15:0] mode_reg, mode_next;
	logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic pin_meta_next, pin_sync_next, pin_prev_next;
	logic start_reg, start_next, capture_reg, capture_next;
	logic [2:0] sts;
	logic [1:0] cis;
	logic [2:0] md;
	logic pin_rise, pin_fall, valid_edge, start_edge, capture_edge, sts_bad;

	// =====================================================
	// mode register; reserved bits and absent bit 11 never stored
	always_comb begin
		mode_next = mode_reg;
		if (mode_wr_en) begin
			mode_next = mode_wr_data & WMASK;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= TMC_RESET_VAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// field views
	assign sts = mode_reg[TMC_STS_HI:TMC_STS_LO];
	assign cis = mode_reg[TMC_CIS_HI:TMC_CIS_LO];
	assign md = mode_reg[TMC_MD_HI:TMC_MD_LO];
	assign mode_rd_data = mode_reg;
	assign op_clock_select = mode_reg[TMC_CKS_HI:TMC_CKS_LO];
	assign count_clock_pin = mode_reg[TMC_CCS_BIT];
	assign start_irq_enable = mode_reg[TMC_MD0_BIT];

	// role and width
	assign is_master = (CHANNEL == TMC_CH_TOP) || (HAS_ROLE && mode_reg[TMC_ROLE_BIT]);
	assign half_width = HAS_SPLIT && mode_reg[TMC_ROLE_BIT];

	// =====================================================
	// operation mode decode and count direction
	always_comb begin
		unique case (md)
			TMC_MD_INTERVAL: op_mode = TMC_OP_INTERVAL;
			TMC_MD_CAPTURE: op_mode = TMC_OP_CAPTURE;
			TMC_MD_EVENT: op_mode = TMC_OP_EVENT;
			TMC_MD_ONECOUNT: op_mode = TMC_OP_ONECOUNT;
			TMC_MD_CAPONE: op_mode = TMC_OP_CAPONE;
			default: op_mode = TMC_OP_BAD;
		endcase
	end

	assign count_up = (op_mode == TMC_OP_CAPTURE) || (op_mode == TMC_OP_CAPONE);
	assign sts_bad = (sts != TMC_STS_SOFT) && (sts != TMC_STS_EDGE) &&
		(sts != TMC_STS_BOTH) && (sts != TMC_STS_MIRQ);
	assign config_error = sts_bad || (op_mode == TMC_OP_BAD);

	// =====================================================
	// pin synchroniser and edge detection; only the second stage reads the first
	always_comb begin
		pin_meta_next = timer_input_pin;
		pin_sync_next = pin_meta_reg;
		pin_prev_next = pin_sync_reg;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
			pin_prev_reg <= pin_prev_next;
		end
	end

	assign pin_rise = pin_sync_reg && !pin_prev_reg;
	assign pin_fall = !pin_sync_reg && pin_prev_reg;

	// valid edge per edge code
	always_comb begin
		unique case (cis)
			TMC_CIS_FALL: valid_edge = pin_fall;
			TMC_CIS_RISE: valid_edge = pin_rise;
			TMC_CIS_LOW: valid_edge = pin_rise || pin_fall;
			TMC_CIS_HIGH: valid_edge = pin_rise || pin_fall;
		endcase
	end

	// split edges: odd codes start on rise, even codes on fall
	assign start_edge = cis[0] ? pin_rise : pin_fall;
	assign capture_edge = cis[0] ? pin_fall : pin_rise;

	// =====================================================
	// trigger selection
	always_comb begin
		start_next = 1'b0;
		capture_next = 1'b0;
		unique case (sts)
			TMC_STS_SOFT: begin
				start_next = sw_start;
			end
			TMC_STS_EDGE: begin
				start_next = sw_start || valid_edge;
				capture_next = valid_edge;
			end
			TMC_STS_BOTH: begin
				start_next = sw_start || start_edge;
				capture_next = capture_edge;
			end
			TMC_STS_MIRQ: begin
				start_next = sw_start || master_irq;
				capture_next = master_irq;
			end
			default: begin
				start_next = 1'b0;
				capture_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			start_reg <= 1'b0;
			capture_reg <= 1'b0;
		end else begin
			start_reg <= start_next;
			capture_reg <= capture_next;
		end
	end

	assign start_trigger = start_reg;
	assign capture_trigger = capture_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	chk_bit11_fixed: assert property (
		!(HAS_ROLE || HAS_SPLIT) |-> (mode_rd_data[TMC_ROLE_BIT] == 1'b0))
		else $error("bit 11 not zero on channel without it");
	chk_master_role: assert property (
		mode_wr_en |=> (is_master == ((CHANNEL == TMC_CH_TOP) ||
			(HAS_ROLE && $past(mode_wr_data[TMC_ROLE_BIT])))))
		else $error("master role does not follow written bit");
	chk_split_width: assert property (
		mode_wr_en |=> (half_width == (HAS_SPLIT && $past(mode_wr_data[TMC_ROLE_BIT]))))
		else $error("half width does not follow written bit");
	chk_soft_only: assert property (
		(sts == TMC_STS_SOFT && !sw_start) |=> (!start_trigger && !capture_trigger))
		else $error("trigger without software start");
	chk_pin_edge: assert property (
		(sts == TMC_STS_EDGE && cis == TMC_CIS_RISE && pin_rise) |=>
			(start_trigger && capture_trigger))
		else $error("rising pin edge did not trigger");
	chk_low_width: assert property (
		(sts == TMC_STS_BOTH && cis == TMC_CIS_LOW && pin_fall && !sw_start) |=>
			(start_trigger && !capture_trigger))
		else $error("falling edge did not start low width");
	chk_high_width: assert property (
		(sts == TMC_STS_BOTH && cis == TMC_CIS_HIGH && pin_fall) |=>
			(capture_trigger && (start_trigger == $past(sw_start))))
		else $error("falling edge did not capture high width");
	chk_master_irq: assert property (
		(sts == TMC_STS_MIRQ && master_irq) |=> (start_trigger && capture_trigger))
		else $error("master interrupt did not trigger");
	chk_count_dir: assert property (
		count_up == (md == TMC_MD_CAPTURE || md == TMC_MD_CAPONE))
		else $error("count direction wrong for mode");
	chk_bad_mode: assert property (
		(md == 3'h1 || md == 3'h5 || md == 3'h7) |-> (config_error && op_mode == TMC_OP_BAD))
		else $error("prohibited mode not flagged");
	chk_fall_edge: assert property (
		(sts == TMC_STS_EDGE && cis == TMC_CIS_FALL && pin_fall) |=>
			(start_trigger && capture_trigger))
		else $error("falling pin edge did not trigger");
	chk_bad_trigger: assert property (
		sts_bad |=> (!start_trigger && !capture_trigger))
		else $error("prohibited trigger code let a trigger through");
	chk_count_down: assert property (
		(md == TMC_MD_INTERVAL || md == TMC_MD_ONECOUNT || md == TMC_MD_EVENT) |->
			!count_up)
		else $error("down counting mode counts up");
	chk_onecount_decode: assert property (
		(md == TMC_MD_ONECOUNT) |-> (op_mode == TMC_OP_ONECOUNT && !config_error || sts_bad))
		else $error("one-count mode not decoded");

	cov_master_start: cover property (sts == TMC_STS_MIRQ && master_irq ##1 start_trigger);
	cov_low_width: cover property (sts == TMC_STS_BOTH && cis == TMC_CIS_LOW && start_trigger
		##[1:50] capture_trigger);
	cov_capone_mode: cover property (op_mode == TMC_OP_CAPONE && capture_trigger);
	cov_fall_edge: cover property (sts == TMC_STS_EDGE && cis == TMC_CIS_FALL && capture_trigger);
	cov_bad_trigger: cover property (sts_bad && sw_start);
endmodule
`default_nettype wire

// [rtl/tmc_pkg.sv]
package tmc_pkg;
	// =====================================================
	// register layout
	localparam int unsigned TMC_REG_W = 16;
	localparam logic [15:0] TMC_RESET_VAL = 16'h0000;
	localparam logic [15:0] TMC_WMASK_BASE = 16'hD7CF; // excludes 13, 11, 5, 4
	localparam logic [15:0] TMC_BIT11_MASK = 16'h0800;
	localparam int unsigned TMC_CKS_HI = 15;
	localparam int unsigned TMC_CKS_LO = 14;
	localparam int unsigned TMC_CCS_BIT = 12;
	localparam int unsigned TMC_ROLE_BIT = 11;
	localparam int unsigned TMC_STS_HI = 10;
	localparam int unsigned TMC_STS_LO = 8;
	localparam int unsigned TMC_CIS_HI = 7;
	localparam int unsigned TMC_CIS_LO = 6;
	localparam int unsigned TMC_MD_HI = 3;
	localparam int unsigned TMC_MD_LO = 1;
	localparam int unsigned TMC_MD0_BIT = 0;
	// =====================================================
	// channel roles
	localparam int unsigned TMC_CH_TOP = 0;
	localparam int unsigned TMC_CH_MASTER = 2;
	localparam int unsigned TMC_CH_SPLIT_A = 1;
	localparam int unsigned TMC_CH_SPLIT_B = 3;
	// =====================================================
	// trigger source codes
	localparam logic [2:0] TMC_STS_SOFT = 3'h0;
	localparam logic [2:0] TMC_STS_EDGE = 3'h1;
	localparam logic [2:0] TMC_STS_BOTH = 3'h2;
	localparam logic [2:0] TMC_STS_MIRQ = 3'h4;
	// edge codes
	localparam logic [1:0] TMC_CIS_FALL = 2'h0;
	localparam logic [1:0] TMC_CIS_RISE = 2'h1;
	localparam logic [1:0] TMC_CIS_LOW = 2'h2;
	localparam logic [1:0] TMC_CIS_HIGH = 2'h3;
	// operation mode codes (bits 3..1)
	localparam logic [2:0] TMC_MD_INTERVAL = 3'h0;
	localparam logic [2:0] TMC_MD_CAPTURE = 3'h2;
	localparam logic [2:0] TMC_MD_EVENT = 3'h3;
	localparam logic [2:0] TMC_MD_ONECOUNT = 3'h4;
	localparam logic [2:0] TMC_MD_CAPONE = 3'h6;
	// decoded operation mode, one-hot
	typedef enum logic [5:0] {
		TMC_OP_INTERVAL = 6'h01,
		TMC_OP_CAPTURE = 6'h02,
		TMC_OP_EVENT = 6'h04,
		TMC_OP_ONECOUNT = 6'h08,
		TMC_OP_CAPONE = 6'h10,
		TMC_OP_BAD = 6'h20
	} tmc_op_t;
endpackage

// [verif/tmc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: timer input pin and master channel interrupt
module tmc_far_model (
	input wire logic clock,
	output logic timer_input_pin,
	output logic master_irq
);
	// pin idles low, interrupt idles inactive
	initial begin
		timer_input_pin = 1'b0;
		master_irq = 1'b0;
	end
	// pin level change just after an edge
	task automatic set_pin(input logic v);
		@(posedge clock);
		#1 timer_input_pin = v;
	endtask
	// one-cycle master interrupt pulse
	task automatic pulse_irq();
		@(posedge clock);
		#1 master_irq = 1'b1;
		@(posedge clock);
		#1 master_irq = 1'b0;
	endtask
endmodule
`default_nettype wire

// [verif/tmc_channel_mode_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_channel_mode_tb import tmc_pkg::*;;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic mode_wr_en = 1'b0;
	logic [15:0] mode_wr_data = 16'h0000;
	logic sw_start = 1'b0;
	logic timer_input_pin, master_irq, start_trigger, capture_trigger, is_master, half_width;
	logic count_clock_pin, count_up, start_irq_enable, config_error, m0, mst1, hw1;
	logic [1:0] op_clock_select;
	logic [15:0] mode_rd_data, rd0, rd1;
	tmc_op_t op_mode;
	int miscompares = 0;
	int checked = 0;
	int s_cnt = 0;
	int c_cnt = 0;
	// {trigger code, edge code, stimulus 0 rise 1 fall 2 irq 3 sw, start, capture}
	localparam logic [8:0] TRIG [19] = '{9'b000_00_11_10, 9'b000_00_00_00, 9'b000_00_10_00,
		9'b001_00_01_11, 9'b001_00_00_00, 9'b001_01_00_11, 9'b001_01_01_00, 9'b001_10_00_11,
		9'b010_00_01_10, 9'b010_00_00_01, 9'b010_01_00_10, 9'b010_01_01_01, 9'b010_10_01_10,
		9'b010_10_00_01, 9'b010_11_00_10, 9'b010_11_01_01, 9'b100_00_10_11, 9'b100_00_00_00,
		9'b011_00_11_00};
	// ==========================================
	// clock, trigger pulse counters, instances
	always #5 clock = ~clock;
	always @(posedge clock) begin
		s_cnt <= s_cnt + int'(start_trigger);
		c_cnt <= c_cnt + int'(capture_trigger);
	end
	tmc_far_model u_far (.clock(clock), .timer_input_pin(timer_input_pin), .master_irq(master_irq));
	tmc_channel_mode #(.CHANNEL(2)) u_dut (.clock(clock), .reset_n(reset_n),
		.mode_wr_en(mode_wr_en), .mode_wr_data(mode_wr_data), .mode_rd_data(mode_rd_data),
		.timer_input_pin(timer_input_pin), .master_irq(master_irq), .sw_start(sw_start),
		.start_trigger(start_trigger), .capture_trigger(capture_trigger),
		.is_master(is_master), .half_width(half_width), .op_clock_select(op_clock_select),
		.count_clock_pin(count_clock_pin), .count_up(count_up),
		.start_irq_enable(start_irq_enable), .op_mode(op_mode), .config_error(config_error));
	tmc_channel_mode #(.CHANNEL(0)) u_ch0 (.clock(clock), .reset_n(reset_n),
		.mode_wr_en(mode_wr_en), .mode_wr_data(mode_wr_data), .mode_rd_data(rd0),
		.timer_input_pin(timer_input_pin), .master_irq(master_irq), .sw_start(sw_start),
		.start_trigger(), .capture_trigger(), .is_master(m0), .half_width(),
		.op_clock_select(), .count_clock_pin(), .count_up(), .start_irq_enable(),
		.op_mode(), .config_error());
	tmc_channel_mode #(.CHANNEL(1)) u_ch1 (.clock(clock), .reset_n(reset_n),
		.mode_wr_en(mode_wr_en), .mode_wr_data(mode_wr_data), .mode_rd_data(rd1),
		.timer_input_pin(timer_input_pin), .master_irq(master_irq), .sw_start(sw_start),
		.start_trigger(), .capture_trigger(), .is_master(mst1), .half_width(hw1),
		.op_clock_select(), .count_clock_pin(), .count_up(), .start_irq_enable(),
		.op_mode(), .config_error());
	// ==========================================
	// compare, verdict, register write
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge clock);
		#1 mode_wr_en = 1'b1;
		mode_wr_data = d;
		@(posedge clock);
		#1 mode_wr_en = 1'b0;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		check("rd", mode_rd_data, 16'h0000);
		check("master2", 16'(is_master), 16'h0000);
		check("master0", 16'(m0), 16'h0001);
		check("mode", {9'h0, config_error, op_mode}, 16'h0001);
		check("fields", {10'h0, half_width, op_clock_select, count_clock_pin, count_up,
			start_irq_enable}, 16'h0000);
		check("half1", 16'(hw1), 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_reg();
		wr(16'hFFFF);
		check("rd2", mode_rd_data, 16'hDFCF);
		check("rd0", rd0, 16'hD7CF);
		check("rd1", rd1, 16'hDFCF);
		check("half1", 16'(hw1), 16'h0001);
		check("master1", 16'(mst1), 16'h0000);
		check("master2", 16'(is_master), 16'h0001);
		check("master0", 16'(m0), 16'h0001);
		check("fields", {10'h0, half_width, op_clock_select, count_clock_pin, count_up,
			start_irq_enable}, 16'h001D);
		check("mode", {9'h0, config_error, op_mode}, 16'h0060);
		reset_n = 1'b0;
		#2;
		check("rd_rst", mode_rd_data, 16'h0000);
		check("master_rst", 16'(is_master), 16'h0000);
		check("half_rst", 16'(hw1), 16'h0000);
		@(posedge clock);
		#1 reset_n = 1'b1;
		$display("test register done");
	endtask
	task automatic t_modes();
		logic [15:0] exp;
		for (int md = 0; md < 8; md++) begin
			wr(16'(md << 1));
			case (md)
				0: exp = 16'h0001;
				2: exp = 16'h0102;
				3: exp = 16'h0004;
				4: exp = 16'h0008;
				6: exp = 16'h0110;
				default: exp = 16'h1020;
			endcase
			check("mode", {3'h0, config_error, 3'h0, count_up, 2'h0, op_mode}, exp);
		end
		$display("test modes done");
	endtask
	task automatic t_trig();
		logic [8:0] e;
		int s_base;
		int c_base;
		for (int i = 0; i < 19; i++) begin
			e = TRIG[i];
			wr({5'h00, e[8:4], 6'h00});
			u_far.set_pin(e[2]);
			repeat (6) @(posedge clock);
			#1 s_base = s_cnt;
			c_base = c_cnt;
			case (e[3:2])
				2'h0, 2'h1: u_far.set_pin(~e[2]);
				2'h2: u_far.pulse_irq();
				default: begin
					@(posedge clock);
					#1 sw_start = 1'b1;
					@(posedge clock);
					#1 sw_start = 1'b0;
				end
			endcase
			repeat (6) @(posedge clock);
			#1;
			check("start", 16'(s_cnt - s_base), 16'(e[1]));
			check("capture", 16'(c_cnt - c_base), 16'(e[0]));
			check("err", 16'(config_error), 16'(e[8:6] == 3'h3));
		end
		$display("test triggers done");
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		#1 reset_n = 1'b1;
		t_reset();
		t_reg();
		t_modes();
		t_trig();
		stop_test();
	end
endmodule
`default_nettype wire
